// ---- sepc_pkg.sv ----
// shared constants for the serial eeprom front end and its host controller
`default_nettype none
package sepc_pkg;
   localparam logic [7:0] SET_WRITE_LATCH_CMD   = 8'h06;
   localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
   localparam logic [7:0] READ_STATUS_CMD       = 8'h05;
   localparam logic [7:0] WRITE_STATUS_CMD      = 8'h01;
   localparam logic [7:0] READ_ARRAY_CMD        = 8'h03;
   localparam logic [7:0] WRITE_ARRAY_CMD       = 8'h02;
   // status byte fields
   localparam int ST_HW_PROTECT_ENABLE   = 7;
   localparam int ST_PROTECT_SELECT_HIGH = 3;
   localparam int ST_PROTECT_SELECT_LOW  = 2;
   localparam int ST_WRITE_LATCH_FLAG    = 1;
   localparam int ST_BUSY                = 0;
   localparam logic [2:0] ST_FIXED_6_4   = 3'h2;
   localparam logic [7:0] ST_WRITABLE_MASK = 8'h8C;
   // frame geometry
   localparam int OPCODE_BITS  = 8;
   localparam int ADDR_BITS    = 16;
   localparam int PAGE_BYTES   = 32;
   localparam int DEF_ARRAY_AW = 11;
   // self-timed write duration
   localparam int WRITE_TIME_MS   = 5;
   localparam int REF_CLK_MHZ     = 250;
   localparam int WRITE_CYCLES    = WRITE_TIME_MS * 1000 * REF_CLK_MHZ;
   // host register map, byte addresses
   localparam logic [7:0] HREG_CTRL   = 8'h00;
   localparam logic [7:0] HREG_ADDR   = 8'h04;
   localparam logic [7:0] HREG_WDATA  = 8'h08;
   localparam logic [7:0] HREG_STATUS = 8'h0C;
   localparam logic [7:0] HREG_RDATA  = 8'h10;
   localparam int HOST_CLK_DIV = 16;
   localparam logic [1:0] AXI_OKAY   = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ---- sepc_if.sv ----
// serial link between host controller and eeprom front end
`default_nettype none
interface sepc_if;
   logic chip_sel_n;
   logic sclk;
   logic mosi;
   logic miso_o;
   logic miso_oe;
   logic wp_n;
   modport host   (output chip_sel_n, output sclk, output mosi, output wp_n,
                   input miso_o, input miso_oe);
   modport device (input chip_sel_n, input sclk, input mosi, input wp_n,
                   output miso_o, output miso_oe);
endinterface
`default_nettype wire

// ---- sepc_sync.sv ----
// two-stage synchroniser for a bundle of link pins
`default_nettype none
module sepc_sync #(
   parameter int W = 4
) (
   input  wire logic         i_ref_clk,
   input  wire logic         i_rst,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sepc_sync_s;
   sepc_sync_s st_ff;
   sepc_sync_s nxt_st;
   always_comb begin
      nxt_st.s1 = i_async;
      nxt_st.s2 = st_ff.s1;
   end
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
   assign o_sync = st_ff.s2;
endmodule
`default_nettype wire

// ---- sepc_device.sv ----
// eeprom serial front end: opcode decode, status, protection, self-timed write
// Behaviour
// - first eight bits after select are opcode
// - sample input on rising serial clock
// - change output on falling serial clock
// - 06 sets, 04 clears write latch
// - 05 reads status, 01 writes status
// - 03 reads array, 02 writes array
// - sixteen address clocks, low bits used
// - select high floats output, standby
// - sequence needs select falling edge first
// - write starts at select rising edge
// - internal write within its maximum time
// - status byte bit layout fixed
// - protect select guards quarter, half, all
// - latch set only by command, auto-clears
// - busy bit set, only status read
// - page write wraps low address bits
// - array read increments and wraps
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`default_nettype none
module sepc_device #(
   parameter int AW         = sepc_pkg::DEF_ARRAY_AW,
   parameter int PAGE       = sepc_pkg::PAGE_BYTES,
   parameter int WRITE_CYC  = sepc_pkg::WRITE_CYCLES
) (
   input  wire logic          i_ref_clk,
   input  wire logic          i_rst,
   sepc_if.device             lnk,
   output logic               o_busy,
   output logic [7:0]         o_status
);
   localparam int PW = $clog2(PAGE);
   typedef enum logic [2:0] {
      SEPC_D_IDLE   = 3'b000,
      SEPC_D_OPC    = 3'b001,
      SEPC_D_ADDR   = 3'b010,
      SEPC_D_RDATA  = 3'b011,
      SEPC_D_WDATA  = 3'b100,
      SEPC_D_STOUT  = 3'b101,
      SEPC_D_STIN   = 3'b110,
      SEPC_D_IGNORE = 3'b111
   } sepc_dstate_e;
   typedef struct packed {
      sepc_dstate_e     state;
      logic [7:0]       opc;
      logic [4:0]       bitcnt;
      logic [15:0]      shin;
      logic [AW-1:0]    addr;
      logic [7:0]       shout;
      logic             miso;
      logic             oe;
      logic             sclk_d;
      logic             cs_n_d;
      logic             write_latch_flag;
      logic             hw_protect_enable;
      logic [1:0]       bp;
      logic             busy;
      logic [31:0]      wcnt;
      logic [PW:0]      pcount;
      logic [AW-1:0]    pbase;
      logic             pend_arr;
      logic             pend_st;
      logic [7:0]       st_new;
      logic [PAGE-1:0][7:0] pbuf;
      logic [PW-1:0]    pfirst;
   } sepc_dev_s;
   logic [7:0]   mem [2**AW];
   sepc_dev_s    st_ff;
   sepc_dev_s    nxt_st;
   logic [3:0]   pins;
   logic         cs_n;
   logic         sclk;
   logic         mosi;
   logic         wp_n;
   logic         rise;
   logic         fall;
   logic         mem_we;
   logic [AW-1:0] mem_wa;
   logic [7:0]   mem_wd;

   sepc_sync #(.W(4)) u_sync (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_async   ({lnk.chip_sel_n, lnk.sclk, lnk.mosi, lnk.wp_n}),
      .o_sync    (pins)
   );
   assign {cs_n, sclk, mosi, wp_n} = pins;
   assign rise = sclk & ~st_ff.sclk_d;
   assign fall = ~sclk & st_ff.sclk_d;

   function automatic logic [7:0] status_byte(input sepc_dev_s s);
      logic [7:0] b;
      b = '0;
      b[sepc_pkg::ST_HW_PROTECT_ENABLE]   = s.hw_protect_enable;
      b[6:4]                              = sepc_pkg::ST_FIXED_6_4;
      b[sepc_pkg::ST_PROTECT_SELECT_HIGH] = s.bp[1];
      b[sepc_pkg::ST_PROTECT_SELECT_LOW]  = s.bp[0];
      b[sepc_pkg::ST_WRITE_LATCH_FLAG]    = s.write_latch_flag;
      b[sepc_pkg::ST_BUSY]                = s.busy;
      return b;
   endfunction

   function automatic logic is_protected(input logic [1:0] bp, input logic [AW-1:0] a);
      logic r;
      case (bp)
         2'b01:   r = (a[AW-1:AW-2] == 2'b11);
         2'b10:   r = a[AW-1];
         2'b11:   r = 1'b1;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   always_comb begin
      nxt_st        = st_ff;
      nxt_st.sclk_d = sclk;
      nxt_st.cs_n_d = cs_n;
      mem_we        = 1'b0;
      mem_wa        = st_ff.addr;
      mem_wd        = '0;
      if (st_ff.busy) begin
         if (st_ff.wcnt == 32'(WRITE_CYC - 1)) begin
            nxt_st.busy = 1'b0;
            nxt_st.write_latch_flag  = 1'b0;
            nxt_st.wcnt = '0;
         end else begin
            nxt_st.wcnt = st_ff.wcnt + 32'd1;
         end
      end
      if (st_ff.pend_arr && st_ff.pcount != '0) begin
         mem_we = 1'b1;
         mem_wa = st_ff.pbase | AW'(st_ff.pfirst);
         mem_wd = st_ff.pbuf[st_ff.pfirst];
         nxt_st.pfirst = st_ff.pfirst + PW'(1);
         nxt_st.pbase  = {st_ff.pbase[AW-1:PW], PW'(0)};
         nxt_st.pcount = st_ff.pcount - (PW+1)'(1);
      end
      if (cs_n) begin
         nxt_st.oe    = 1'b0;
         nxt_st.state = SEPC_D_IDLE;
         if (!st_ff.cs_n_d) begin
            if (st_ff.state == SEPC_D_WDATA && st_ff.bitcnt == '0 && st_ff.pcount != '0
                && !st_ff.busy) begin
               nxt_st.busy     = 1'b1;
               nxt_st.pend_arr = 1'b1;
               nxt_st.pfirst   = st_ff.addr[PW-1:0] - PW'(st_ff.pcount);
            end else begin
               nxt_st.pcount   = '0;
            end
            if (st_ff.pend_st) begin
               nxt_st.hw_protect_enable    = st_ff.st_new[sepc_pkg::ST_HW_PROTECT_ENABLE];
               nxt_st.bp      = st_ff.st_new[3:2];
               nxt_st.busy    = 1'b1;
               nxt_st.pend_st = 1'b0;
            end
         end
      end else if (st_ff.cs_n_d) begin
         // framing starts on select falling edge
         nxt_st.state  = SEPC_D_OPC;
         nxt_st.bitcnt = '0;
         nxt_st.pend_arr = 1'b0;
      end else begin
         if (rise) begin
            nxt_st.shin   = {st_ff.shin[14:0], mosi};
            nxt_st.bitcnt = st_ff.bitcnt + 5'd1;
         end
         case (st_ff.state)
            SEPC_D_OPC: if (rise && st_ff.bitcnt == 5'(sepc_pkg::OPCODE_BITS - 1)) begin
               nxt_st.opc    = {st_ff.shin[6:0], mosi};
               nxt_st.bitcnt = '0;
               nxt_st.state  = SEPC_D_IGNORE;
               // busy blocks all but status read
               if ({st_ff.shin[6:0], mosi} == sepc_pkg::READ_STATUS_CMD) begin
                  nxt_st.state = SEPC_D_STOUT;
                  nxt_st.shout = status_byte(st_ff);
               end else if (!st_ff.busy) begin
                  case ({st_ff.shin[6:0], mosi})
                     sepc_pkg::SET_WRITE_LATCH_CMD:   nxt_st.write_latch_flag = 1'b1;
                     sepc_pkg::CLEAR_WRITE_LATCH_CMD: nxt_st.write_latch_flag = 1'b0;
                     sepc_pkg::WRITE_STATUS_CMD:      nxt_st.state = SEPC_D_STIN;
                     sepc_pkg::READ_ARRAY_CMD:        nxt_st.state = SEPC_D_ADDR;
                     sepc_pkg::WRITE_ARRAY_CMD:       nxt_st.state = SEPC_D_ADDR;
                     default:                         nxt_st.state = SEPC_D_IGNORE;
                  endcase
               end
            end
            SEPC_D_ADDR: if (rise && st_ff.bitcnt == 5'(sepc_pkg::ADDR_BITS - 1)) begin
               nxt_st.addr   = AW'({st_ff.shin[14:0], mosi});
               nxt_st.bitcnt = '0;
               nxt_st.pcount = '0;
               if (st_ff.opc == sepc_pkg::READ_ARRAY_CMD) begin
                  nxt_st.state = SEPC_D_RDATA;
                  nxt_st.shout = mem[AW'({st_ff.shin[14:0], mosi})];
               end else begin
                  nxt_st.state = SEPC_D_WDATA;
                  nxt_st.pbase = AW'({st_ff.shin[14:0], mosi});
               end
            end
            SEPC_D_RDATA, SEPC_D_STOUT: begin
               if (fall) begin
                  nxt_st.oe    = 1'b1;
                  nxt_st.miso  = st_ff.shout[7];
                  nxt_st.shout = {st_ff.shout[6:0], 1'b0};
               end
               if (rise && st_ff.bitcnt == 5'd7) begin
                  nxt_st.bitcnt = '0;
                  if (st_ff.state == SEPC_D_RDATA) begin
                     nxt_st.addr  = st_ff.addr + AW'(1);
                     nxt_st.shout = mem[st_ff.addr + AW'(1)];
                  end else begin
                     nxt_st.shout = status_byte(st_ff);
                  end
               end
            end
            SEPC_D_WDATA: if (rise && st_ff.bitcnt == 5'd7) begin
               nxt_st.bitcnt = '0;
               if (st_ff.write_latch_flag && !is_protected(st_ff.bp, st_ff.addr)) begin
                  nxt_st.pbuf[st_ff.addr[PW-1:0]] = {st_ff.shin[6:0], mosi};
                  if (st_ff.pcount != (PW+1)'(PAGE)) begin
                     nxt_st.pcount = st_ff.pcount + (PW+1)'(1);
                  end
               end
               nxt_st.addr = {st_ff.addr[AW-1:PW], st_ff.addr[PW-1:0] + PW'(1)};
            end
            SEPC_D_STIN: if (rise && st_ff.bitcnt == 5'd7) begin
               nxt_st.state  = SEPC_D_IGNORE;
               nxt_st.st_new = {st_ff.shin[6:0], mosi};
               nxt_st.pend_st = st_ff.write_latch_flag && !(st_ff.hw_protect_enable && !wp_n);
            end
            SEPC_D_IGNORE: nxt_st.oe = 1'b0;
            default:       nxt_st.state = SEPC_D_IGNORE;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         st_ff        <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
   always_ff @(posedge i_ref_clk) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end
   logic [7:0] stat_ff;
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         stat_ff <= {1'b0, sepc_pkg::ST_FIXED_6_4, 4'h0};
      end else begin
         stat_ff <= status_byte(nxt_st);
      end
   end
   assign o_status    = stat_ff;
   assign o_busy      = st_ff.busy;
   assign lnk.miso_o  = st_ff.miso;
   assign lnk.miso_oe = st_ff.oe;
endmodule
`default_nettype wire

// ---- sepc_host.sv ----
// host spi controller with axi4-lite command registers
`default_nettype none
module sepc_host #(
   parameter int DIV = sepc_pkg::HOST_CLK_DIV
) (
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst,
   sepc_if.host             lnk,
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   output logic [1:0]       o_bresp,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   input  wire logic [7:0]  i_araddr,
   input  wire logic        i_arvalid,
   output logic             o_arready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   output logic             o_rvalid,
   input  wire logic        i_rready
);
   typedef struct packed {
      logic        aw_got;
      logic [7:0]  aw;
      logic        w_got;
      logic [31:0] wd;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        busy;
      logic [7:0]  opc;
      logic [15:0] addr;
      logic [7:0]  wbyte;
      logic [7:0]  rbyte;
      logic [7:0]  nbytes;
      logic [39:0] sh;
      logic [5:0]  nbits;
      logic [7:0]  div;
      logic        sclk;
      logic        cs_n;
      logic        mosi;
      logic        wp_n;
   } sepc_host_s;
   sepc_host_s st_ff;
   sepc_host_s nxt_st;
   logic [3:0] syn;
   logic       miso;
   sepc_sync #(.W(4)) u_sync (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_async   ({lnk.miso_o & lnk.miso_oe, 3'h0}),
      .o_sync    (syn)
   );
   assign miso = syn[3];

   always_comb begin
      nxt_st = st_ff;
      if (i_awvalid && !st_ff.aw_got && !st_ff.bvalid) begin
         nxt_st.aw_got = 1'b1;
         nxt_st.aw     = i_awaddr;
      end
      if (i_wvalid && !st_ff.w_got && !st_ff.bvalid) begin
         nxt_st.w_got = 1'b1;
         nxt_st.wd    = i_wdata;
      end
      if (st_ff.bvalid && i_bready) begin
         nxt_st.bvalid = 1'b0;
      end
      if (st_ff.aw_got && st_ff.w_got) begin
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got  = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp  = sepc_pkg::AXI_OKAY;
         case (st_ff.aw)
            sepc_pkg::HREG_ADDR:  nxt_st.addr  = st_ff.wd[15:0];
            sepc_pkg::HREG_WDATA: nxt_st.wbyte = st_ff.wd[7:0];
            sepc_pkg::HREG_CTRL: begin
               nxt_st.wp_n = ~st_ff.wd[16];
               if (!st_ff.busy) begin
                  // frame: opcode, optional address, bytes
                  nxt_st.busy   = 1'b1;
                  nxt_st.opc    = st_ff.wd[7:0];
                  nxt_st.nbytes = st_ff.wd[15:8];
                  nxt_st.cs_n   = 1'b0;
                  nxt_st.div    = '0;
                  if (st_ff.wd[7:0] == sepc_pkg::READ_ARRAY_CMD ||
                      st_ff.wd[7:0] == sepc_pkg::WRITE_ARRAY_CMD) begin
                     nxt_st.sh    = {st_ff.wd[7:0], st_ff.addr, st_ff.wbyte, 8'h00};
                     nxt_st.nbits = 6'd32;
                  end else begin
                     nxt_st.sh    = {st_ff.wd[7:0], st_ff.wbyte, 24'h0};
                     nxt_st.nbits = (st_ff.wd[15:8] != '0) ? 6'd16 : 6'd8;
                  end
               end
            end
            default: nxt_st.bresp = (st_ff.aw == sepc_pkg::HREG_STATUS ||
                                     st_ff.aw == sepc_pkg::HREG_RDATA) ?
                                    sepc_pkg::AXI_OKAY : sepc_pkg::AXI_SLVERR;
         endcase
      end
      if (st_ff.rvalid && i_rready) begin
         nxt_st.rvalid = 1'b0;
      end else if (i_arvalid && !st_ff.rvalid) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp  = sepc_pkg::AXI_OKAY;
         case (i_araddr)
            sepc_pkg::HREG_CTRL:   nxt_st.rdata = {15'h0, ~st_ff.wp_n, st_ff.nbytes, st_ff.opc};
            sepc_pkg::HREG_ADDR:   nxt_st.rdata = {16'h0, st_ff.addr};
            sepc_pkg::HREG_WDATA:  nxt_st.rdata = {24'h0, st_ff.wbyte};
            sepc_pkg::HREG_STATUS: nxt_st.rdata = {31'h0, st_ff.busy};
            sepc_pkg::HREG_RDATA:  nxt_st.rdata = {24'h0, st_ff.rbyte};
            default: begin
               nxt_st.rdata = '0;
               nxt_st.rresp = sepc_pkg::AXI_SLVERR;
            end
         endcase
      end
      // serial engine, mode 0 with divided clock
      if (st_ff.busy) begin
         nxt_st.div = st_ff.div + 8'd1;
         if (st_ff.div == 8'(DIV/2 - 1)) begin
            nxt_st.div = '0;
            if (st_ff.cs_n) begin
               nxt_st.busy = 1'b0;
            end else if (!st_ff.sclk) begin
               if (st_ff.nbits == '0) begin
                  nxt_st.cs_n = 1'b1;
               end else begin
                  nxt_st.sclk  = 1'b1;
                  nxt_st.rbyte = {st_ff.rbyte[6:0], miso};
               end
            end else begin
               nxt_st.sclk  = 1'b0;
               nxt_st.sh    = {st_ff.sh[38:0], 1'b0};
               nxt_st.nbits = st_ff.nbits - 6'd1;
               if (st_ff.nbits == 6'd1 && st_ff.nbytes > 8'd1 &&
                   st_ff.opc == sepc_pkg::READ_ARRAY_CMD) begin
                  nxt_st.nbits  = 6'd8;
                  nxt_st.nbytes = st_ff.nbytes - 8'd1;
               end
            end
         end
         nxt_st.mosi = nxt_st.sh[39];
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         st_ff      <= '0;
         st_ff.cs_n <= 1'b1;
         st_ff.wp_n <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end
   assign o_awready      = i_awvalid && !st_ff.aw_got && !st_ff.bvalid;
   assign o_wready       = i_wvalid && !st_ff.w_got && !st_ff.bvalid;
   assign o_bvalid       = st_ff.bvalid;
   assign o_bresp        = st_ff.bresp;
   assign o_arready      = i_arvalid && !st_ff.rvalid;
   assign o_rvalid       = st_ff.rvalid;
   assign o_rdata        = st_ff.rdata;
   assign o_rresp        = st_ff.rresp;
   assign lnk.chip_sel_n = st_ff.cs_n;
   assign lnk.sclk       = st_ff.sclk;
   assign lnk.mosi       = st_ff.mosi;
   assign lnk.wp_n       = st_ff.wp_n;
endmodule
`default_nettype wire

// ---- sepc_monitor.sv ----
// link checker for the serial eeprom pair
`default_nettype none
module sepc_monitor #(
   parameter int WRITE_CYC = 800
) (
   input wire logic       i_ref_clk,
   input wire logic       i_rst,
   input wire logic       chip_sel_n,
   input wire logic       sclk,
   input wire logic       miso_o,
   input wire logic       miso_oe,
   input wire logic       o_busy,
   input wire logic [7:0] o_status
);
   localparam int BMAX = WRITE_CYC + 8;
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_rst);
   AST_IDLE_HIZ: assert property (chip_sel_n [*6] |-> !miso_oe)
      else $error("output driven while idle");
   AST_OE_SEL: assert property ($rose(miso_oe) |-> !chip_sel_n)
      else $error("output driven unselected");
   AST_OUT_FALL: assert property (
      $changed(miso_o) && miso_oe && $past(miso_oe) |-> !$past(sclk, 2))
      else $error("output moved off falling edge");
   AST_SEL_IDLE: assert property ($fell(chip_sel_n) |-> !sclk)
      else $error("select fell with clock high");
   AST_WR_START: assert property ($rose(o_busy) |-> chip_sel_n && $past(chip_sel_n, 2))
      else $error("write began while selected");
   AST_WR_TIME: assert property ($rose(o_busy) |-> ##[1:BMAX] !o_busy)
      else $error("write cycle too long");
   AST_FIXED: assert property (o_status[6:4] == sepc_pkg::ST_FIXED_6_4)
      else $error("fixed status bits wrong");
   AST_BUSY_BIT: assert property (o_status[0] == o_busy)
      else $error("busy bit mismatch");
   AST_LATCH_CLR: assert property ($fell(o_busy) |-> ##[0:1] !o_status[1])
      else $error("latch kept after write");
   cover property ($rose(o_busy));
   cover property ($rose(miso_oe));
   cover property ($fell(chip_sel_n));
endmodule
`default_nettype wire

// ---- spi_eeprom_command_protect_tb_top.sv ----
// bench: host controller driving the eeprom front end
`default_nettype none
module spi_eeprom_command_protect_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WCYC = 800;
   logic        i_ref_clk, i_rst, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, busy;
   logic [7:0]  awaddr, araddr, status;
   logic [31:0] wdata, rdata, rd;
   logic [1:0]  bresp, rresp, resp;
   int          n_fail = 0, num_checks = 0, cyc = 0;
   sepc_if lnk ();
   sepc_device #(.WRITE_CYC(WCYC)) sepc_device_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
      .lnk(lnk), .o_busy(busy), .o_status(status));
   sepc_host sepc_host_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .lnk(lnk),
      .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
      .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
      .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
      .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
      .i_rready(rready));
   sepc_monitor #(.WRITE_CYC(WCYC)) sepc_monitor_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
      .chip_sel_n(lnk.chip_sel_n), .sclk(lnk.sclk), .miso_o(lnk.miso_o),
      .miso_oe(lnk.miso_oe), .o_busy(busy), .o_status(status));
   initial begin
      i_ref_clk = 1'b0;
      forever #2 i_ref_clk = ~i_ref_clk;
   end
   task automatic summarize();
      $display("checks=%0d fails=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge i_ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_fail++;
         summarize();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge i_ref_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
      @(posedge i_ref_clk);
   endtask
   task automatic rdr(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge i_ref_clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
      @(posedge i_ref_clk);
   endtask
   task automatic fr(input logic [7:0] op, input logic [15:0] ad, input logic [7:0] wd,
                     input logic [7:0] n, input logic wp);
      wr(sepc_pkg::HREG_ADDR, {16'h0000, ad});
      wr(sepc_pkg::HREG_WDATA, {24'h00_0000, wd});
      wr(sepc_pkg::HREG_CTRL, {15'h0000, wp, n, op});
      do rdr(sepc_pkg::HREG_STATUS);
      while (rd[0] !== 1'b0);
      repeat (8) @(posedge i_ref_clk);
   endtask
   task automatic read_status_cmd(input logic [7:0] e);
      fr(sepc_pkg::READ_STATUS_CMD, 16'h0000, 8'h00, 8'h01, 1'b0);
      rdr(sepc_pkg::HREG_RDATA);
      chk(rd[7:0], e);
   endtask
   task automatic set_write_latch_cmd();
      fr(sepc_pkg::SET_WRITE_LATCH_CMD, 16'h0000, 8'h00, 8'h00, 1'b0);
   endtask
   task automatic wrt(input logic [15:0] ad, input logic [7:0] d);
      fr(sepc_pkg::WRITE_ARRAY_CMD, ad, d, 8'h01, 1'b0);
   endtask
   initial begin
      i_rst = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata} = 48'h0000_0000_0000;
      repeat (16) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      chk(status, 8'h20);
      read_status_cmd(8'h20);
      set_write_latch_cmd();
      read_status_cmd(8'h22);
      fr(sepc_pkg::CLEAR_WRITE_LATCH_CMD, 16'h0000, 8'h00, 8'h00, 1'b0);
      read_status_cmd(8'h20);
      fr(8'hAB, 16'h0000, 8'h00, 8'h01, 1'b0);
      chk(status, 8'h20);
      set_write_latch_cmd();
      fr(sepc_pkg::WRITE_STATUS_CMD, 16'h0000, 8'hFF, 8'h01, 1'b0);
      while (busy !== 1'b0) @(posedge i_ref_clk);
      chk(status, 8'hAC);
      set_write_latch_cmd();
      wrt(16'h0010, 8'h5A);
      chk(status, 8'hAE);
      fr(sepc_pkg::WRITE_STATUS_CMD, 16'h0000, 8'h00, 8'h01, 1'b1);
      chk(status, 8'hAE);
      fr(sepc_pkg::WRITE_STATUS_CMD, 16'h0000, 8'h00, 8'h01, 1'b0);
      while (busy !== 1'b0) @(posedge i_ref_clk);
      chk(status, 8'h20);
      set_write_latch_cmd();
      wrt(16'hF812, 8'h5A);
      chk(busy, 1'b1);
      read_status_cmd(8'h23);
      fr(sepc_pkg::CLEAR_WRITE_LATCH_CMD, 16'h0000, 8'h00, 8'h00, 1'b0);
      chk(status, 8'h23);
      while (busy !== 1'b0) @(posedge i_ref_clk);
      chk(status, 8'h20);
      set_write_latch_cmd();
      wrt(16'h0000, 8'h3C);
      while (busy !== 1'b0) @(posedge i_ref_clk);
      fr(sepc_pkg::READ_ARRAY_CMD, 16'h0012, 8'h00, 8'h01, 1'b0);
      rdr(sepc_pkg::HREG_RDATA);
      chk(rd[7:0], 8'h5A);
      fr(sepc_pkg::READ_ARRAY_CMD, 16'h07FF, 8'h00, 8'h02, 1'b0);
      rdr(sepc_pkg::HREG_RDATA);
      chk(rd[7:0], 8'h3C);
      wr(8'h20, 32'h0000_0000);
      chk(resp, sepc_pkg::AXI_SLVERR);
      rdr(8'h20);
      chk(resp, sepc_pkg::AXI_SLVERR);
      summarize();
   end
endmodule
`default_nettype wire
